// [core/hmws_regs.svh]
`ifndef HMWS_REGS_SVH
`define HMWS_REGS_SVH

// System clocks the core clock keeps running after the halt request
`define HMWS_FLUSH_SHORT 7'h20
`define HMWS_FLUSH_LONG 7'h40
// System clocks from the entry instruction to the clock output going low
`define HMWS_CLKOUT_LOW_MIN 7'h20
`define HMWS_CLKOUT_LOW_MAX 7'h2d
// Lock interval in oscillator clocks (131072)
`define HMWS_LOCK_OSC 18'h20000
// System clocks from lock to execution resume
`define HMWS_RESUME_RAM 18'h00023
`define HMWS_RESUME_FLASH 18'h00465
// Default clk cycles per oscillator clock
`define HMWS_OSC_DIV 8'h0a

`endif

// [core/hmws_pkg.sv]
package hmws_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_RUN,
    ST_FLUSH,
    ST_HALT,
    ST_OSC_WAIT,
    ST_LOCK,
    ST_RESUME
  } hmws_state_t;

  typedef logic [17:0] hmws_cnt_t;
  typedef logic [6:0] hmws_flush_t;

endpackage : hmws_pkg

// [core/hmws_cnt_if.sv]
`timescale 1ns/1ns

// Control of the shared interval counter
interface hmws_cnt_if;
  logic load;
  hmws_pkg::hmws_cnt_t load_val;
  logic tick;
  logic done;

  modport ctl (output load, output load_val, output tick, input done);
  modport cnt (input load, input load_val, input tick, output done);
endinterface : hmws_cnt_if

// [core/hmws_counter.sv]
`timescale 1ns/1ns

module hmws_counter (
  input wire logic clk,
  input wire logic rstn,
  hmws_cnt_if.cnt bus
);

  hmws_pkg::hmws_cnt_t count;
  hmws_pkg::hmws_cnt_t next_count;

  // Load wins over a tick so a fresh interval always starts at its full length
  always_comb begin
    next_count = count;
    if (bus.load) begin
      next_count = bus.load_val;
    end else if (bus.tick && (count != 18'h00000)) begin
      next_count = count - 18'h00001;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= 18'h00000;
    end else begin
      count <= next_count;
    end
  end

  // Done is a level while the count stands at zero
  assign bus.done = (count == 18'h00000);

endmodule : hmws_counter

// [core/hmws_top.sv]
// Operation
// - Entry instruction with deepest mode selected starts the halt entry sequence.
// - System clock keeps running 32 cycles, or 64 with clock halve set.
// - Clock output goes low 32 to 45 system clocks after entry.
// - Halt stops peripheral clocks, PLL, and oscillator when a crystal is used.
// - Falling wake pin edge restarts the oscillator and starts the wake sequence.
// - Stable oscillator is followed by 131072 oscillator clocks of lock wait.
// - Full lock wait applies even with the PLL disabled or bypassed.
// - After lock, clocks return, halt ends, wake interrupt follows if enabled.
// - Execution resumes 35 clocks after lock from RAM, 1125 from sleeping flash.
`timescale 1ns/1ns
`include "hmws_regs.svh"

module hmws_top #(
  parameter logic [17:0] LOCK_CYCLES = `HMWS_LOCK_OSC,
  parameter logic [7:0] OSC_DIV = `HMWS_OSC_DIV
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic idle_exec,
  input wire logic halt_mode_sel,
  input wire logic input_clock_halve_select,
  input wire logic crystal_used,
  input wire logic pll_bypass,
  input wire logic run_from_flash,
  input wire logic wake_int_en,
  input wire logic wake_gpio_pin,
  input wire logic external_reset_pin_n,
  input wire logic osc_stable,
  output logic system_clock_en,
  output logic clock_output_en,
  output logic core_clk_en,
  output logic periph_clk_en,
  output logic pll_power_down,
  output logic osc_power_down,
  output logic in_halt,
  output logic exec_resume,
  output logic wake_int_req
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic wake_pin_prev;
  logic wake_fall;
  logic reset_pin_low;
  logic osc_ok;

  // Pins are asynchronous; first stage feeds only the second stage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_meta <= 3'h7;
      pin_sync <= 3'h7;
      wake_pin_prev <= 1'b1;
    end else begin
      pin_meta <= {osc_stable, external_reset_pin_n, wake_gpio_pin};
      pin_sync <= pin_meta;
      wake_pin_prev <= pin_sync[0];
    end
  end

  assign wake_fall = wake_pin_prev && !pin_sync[0];
  assign reset_pin_low = !pin_sync[1];
  assign osc_ok = pin_sync[2];

  // ****************************************************************
  // Oscillator clock enable
  // ****************************************************************
  logic [7:0] div_cnt;
  logic [7:0] next_div_cnt;
  logic osc_tick;
  logic next_osc_tick;

  // One-cycle pulse per oscillator period, used to pace the lock wait
  always_comb begin
    next_div_cnt = div_cnt + 8'h01;
    next_osc_tick = 1'b0;
    if (div_cnt >= (OSC_DIV - 8'h01)) begin
      next_div_cnt = 8'h00;
      next_osc_tick = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_cnt <= 8'h00;
      osc_tick <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      osc_tick <= next_osc_tick;
    end
  end

  // ****************************************************************
  // Halt sequencer
  // ****************************************************************
  hmws_cnt_if cnt_bus ();

  hmws_counter u_counter (
    .clk(clk),
    .rstn(rstn),
    .bus(cnt_bus)
  );

  hmws_pkg::hmws_state_t state;
  hmws_pkg::hmws_state_t next_state;
  hmws_pkg::hmws_flush_t flush_cnt;
  hmws_pkg::hmws_flush_t next_flush_cnt;
  hmws_pkg::hmws_flush_t flush_len;
  logic next_system_clock_en;
  logic next_clock_output_en;
  logic next_core_clk_en;
  logic next_periph_clk_en;
  logic next_pll_power_down;
  logic next_osc_power_down;
  logic next_in_halt;
  logic next_exec_resume;
  logic next_wake_int_req;

  // Flush length follows the clock halve select
  assign flush_len = input_clock_halve_select ? `HMWS_FLUSH_LONG : `HMWS_FLUSH_SHORT;

  // Next state and outputs
  always_comb begin
    next_state = state;
    next_flush_cnt = flush_cnt;
    next_system_clock_en = system_clock_en;
    next_clock_output_en = clock_output_en;
    next_core_clk_en = core_clk_en;
    next_periph_clk_en = periph_clk_en;
    next_pll_power_down = pll_power_down;
    next_osc_power_down = osc_power_down;
    next_in_halt = in_halt;
    next_exec_resume = 1'b0;
    next_wake_int_req = 1'b0;
    cnt_bus.load = 1'b0;
    cnt_bus.load_val = LOCK_CYCLES;
    cnt_bus.tick = 1'b0;
    unique case (state)
      hmws_pkg::ST_RUN: begin
        if (idle_exec && halt_mode_sel) begin
          next_state = hmws_pkg::ST_FLUSH;
          next_flush_cnt = 7'h01;
        end
      end
      hmws_pkg::ST_FLUSH: begin
        // Flush count equals the edges seen since entry, so compare the full lengths
        next_flush_cnt = flush_cnt + 7'h01;
        // Fixed at the lower bound, inside the 32 to 45 window
        if (flush_cnt == `HMWS_CLKOUT_LOW_MIN) begin
          next_clock_output_en = 1'b0;
        end
        if (flush_cnt >= flush_len) begin
          next_state = hmws_pkg::ST_HALT;
          next_system_clock_en = 1'b0;
          next_clock_output_en = 1'b0;
          next_core_clk_en = 1'b0;
          next_periph_clk_en = 1'b0;
          next_pll_power_down = 1'b1;
          next_osc_power_down = crystal_used;
          next_in_halt = 1'b1;
        end
      end
      hmws_pkg::ST_HALT: begin
        // Reset pin low also leaves halt; its hold time is the far side's duty
        if (wake_fall || reset_pin_low) begin
          next_state = hmws_pkg::ST_OSC_WAIT;
          next_osc_power_down = 1'b0;
          next_pll_power_down = 1'b0;
        end
      end
      hmws_pkg::ST_OSC_WAIT: begin
        // Source holds the pin low until stable, so a high pin is not an abort
        if (osc_ok || !crystal_used) begin
          next_state = hmws_pkg::ST_LOCK;
          cnt_bus.load = 1'b1;
          cnt_bus.load_val = LOCK_CYCLES;
        end
      end
      hmws_pkg::ST_LOCK: begin
        // Bypass still waits the whole count; pll_bypass is deliberately unused here
        cnt_bus.tick = osc_tick;
        if (cnt_bus.done) begin
          next_state = hmws_pkg::ST_RESUME;
          next_system_clock_en = 1'b1;
          next_clock_output_en = 1'b1;
          next_core_clk_en = 1'b1;
          next_periph_clk_en = 1'b1;
          next_in_halt = 1'b0;
          cnt_bus.load = 1'b1;
          // Less one: the resume pulse is registered a cycle after the count empties
          cnt_bus.load_val = (run_from_flash ? `HMWS_RESUME_FLASH : `HMWS_RESUME_RAM)
            - 18'h00001;
        end
      end
      hmws_pkg::ST_RESUME: begin
        cnt_bus.tick = 1'b1;
        // Wake edges are not looked at until back in halt
        if (cnt_bus.done) begin
          next_state = hmws_pkg::ST_RUN;
          next_exec_resume = 1'b1;
          next_wake_int_req = wake_int_en;
        end
      end
      default: begin
        next_state = hmws_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= hmws_pkg::ST_RUN;
      flush_cnt <= 7'h00;
      system_clock_en <= 1'b1;
      clock_output_en <= 1'b1;
      core_clk_en <= 1'b1;
      periph_clk_en <= 1'b1;
      pll_power_down <= 1'b0;
      osc_power_down <= 1'b0;
      in_halt <= 1'b0;
      exec_resume <= 1'b0;
      wake_int_req <= 1'b0;
    end else begin
      state <= next_state;
      flush_cnt <= next_flush_cnt;
      system_clock_en <= next_system_clock_en;
      clock_output_en <= next_clock_output_en;
      core_clk_en <= next_core_clk_en;
      periph_clk_en <= next_periph_clk_en;
      pll_power_down <= next_pll_power_down;
      osc_power_down <= next_osc_power_down;
      in_halt <= next_in_halt;
      exec_resume <= next_exec_resume;
      wake_int_req <= next_wake_int_req;
    end
  end

endmodule : hmws_top

// [tb/hmws_monitor.sv]
`timescale 1ns/1ns
// ****
// Halt sequencer port checks
// ****
module hmws_monitor #(
  parameter logic [17:0] LOCK_CYCLES = 18'h20000,
  parameter logic [7:0] OSC_DIV = 8'h0a
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic idle_exec,
  input wire logic halt_mode_sel,
  input wire logic input_clock_halve_select,
  input wire logic crystal_used,
  input wire logic run_from_flash,
  input wire logic wake_int_en,
  input wire logic wake_gpio_pin,
  input wire logic osc_stable,
  input wire logic system_clock_en,
  input wire logic clock_output_en,
  input wire logic core_clk_en,
  input wire logic periph_clk_en,
  input wire logic pll_power_down,
  input wire logic osc_power_down,
  input wire logic in_halt,
  input wire logic exec_resume,
  input wire logic wake_int_req
);
  logic armed;
  logic in_halt_d;
  logic start;
  int lock_n;
  int since;
  // Entry only counts from run; a resume arms the next one
  assign start = idle_exec && halt_mode_sel && armed;
  // Lock length and time since exit, so long counts need no repetition
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      armed <= 1'b1;
      in_halt_d <= 1'b0;
      lock_n <= 0;
      since <= 0;
    end else begin
      armed <= exec_resume || (armed && !start);
      in_halt_d <= in_halt;
      lock_n <= !in_halt ? 0 : lock_n + int'(!pll_power_down && osc_stable);
      // Own edge flop keeps the sampled-value clock out of a two-event process
      since <= (in_halt_d && !in_halt) ? 1 : since + 1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Everything that halt switches off except the clock output
  sequence s_halted;
    !system_clock_en && !core_clk_en && !periph_clk_en && pll_power_down && in_halt
      && osc_power_down == crystal_used;
  endsequence
  a_clkout_low: assert property (start |-> ##31 clock_output_en ##2 !clock_output_en)
    else $error("clock output low at wrong time");
  a_flush_short: assert property (start && !input_clock_halve_select |-> ##32 !in_halt ##1 s_halted)
    else $error("short flush wrong");
  a_flush_long: assert property (start && input_clock_halve_select |-> ##64 !in_halt ##1 s_halted)
    else $error("long flush wrong");
  a_wake_power: assert property (in_halt && pll_power_down && $fell(wake_gpio_pin) |-> ##[2:8] !pll_power_down && !osc_power_down)
    else $error("wake edge did not power up");
  a_lock_exit: assert property ($fell(in_halt) |-> system_clock_en && core_clk_en && periph_clk_en && lock_n >= LOCK_CYCLES * OSC_DIV && lock_n <= LOCK_CYCLES * OSC_DIV + OSC_DIV + 8)
    else $error("lock interval or exit wrong");
  a_resume_time: assert property (exec_resume |-> since >= (run_from_flash ? 1125 : 35) && since <= (run_from_flash ? 1128 : 38))
    else $error("resume delay wrong");
  a_int_gate: assert property (wake_int_req == (exec_resume && wake_int_en))
    else $error("wake interrupt request wrong");
  a_resume_once: assert property (exec_resume |-> !armed)
    else $error("extra resume");
endmodule : hmws_monitor

bind hmws_top hmws_monitor #(.LOCK_CYCLES(LOCK_CYCLES), .OSC_DIV(OSC_DIV)) mon (.clk, .rstn,
  .idle_exec, .halt_mode_sel, .input_clock_halve_select, .crystal_used, .run_from_flash,
  .wake_int_en, .wake_gpio_pin, .osc_stable, .system_clock_en, .clock_output_en, .core_clk_en,
  .periph_clk_en, .pll_power_down, .osc_power_down, .in_halt, .exec_resume, .wake_int_req);

// [tb/hmws_wake_src.sv]
`timescale 1ns/1ns
// ****
// Wake source and oscillator
// ****
module hmws_wake_src #(parameter int OSC_DIV = 2) (
  input wire logic clk,
  input wire logic osc_power_down,
  output logic wake_gpio_pin,
  output logic external_reset_pin_n,
  output logic osc_stable
);
  int st = 9;
  initial {wake_gpio_pin, external_reset_pin_n, osc_stable} = 3'h7;
  // Oscillator settles some clocks after power-up and is lost at once when off
  always @(posedge clk) begin
    st <= osc_power_down ? 0 : st + 1;
    osc_stable <= #1 !osc_power_down && st > 5;
  end
  // Pin held low past oscillator settling, then one stray edge during lock
  task automatic wake(input logic use_rst);
    @(posedge clk);
    #1 {external_reset_pin_n, wake_gpio_pin} = use_rst ? 2'h1 : 2'h2;
    do @(posedge clk); while (osc_stable !== 1'b1);
    repeat ((use_rst ? 8 : 2) * OSC_DIV + 4) @(posedge clk);
    #1 {external_reset_pin_n, wake_gpio_pin} = 2'h3;
    repeat (3) @(posedge clk);
    #1 wake_gpio_pin = 1'b0;
    repeat (3) @(posedge clk);
    #1 wake_gpio_pin = 1'b1;
  endtask : wake
endmodule : hmws_wake_src

// [tb/tb_halt_mode_wake_sequencer.sv]
`timescale 1ns/1ns
// ****
// Halt entry and wake bench
// ****
module tb_halt_mode_wake_sequencer;
  localparam logic [17:0] LOCK = 18'h00010;
  localparam logic [7:0] DIV = 8'h02;
  logic clk, rstn, idle_exec, halt_mode_sel, input_clock_halve_select, crystal_used;
  logic pll_bypass, run_from_flash, wake_int_en, wake_gpio_pin, external_reset_pin_n;
  logic osc_stable, system_clock_en, clock_output_en, core_clk_en, periph_clk_en;
  logic pll_power_down, osc_power_down, in_halt, exec_resume, wake_int_req, was_halt;
  logic was_pd;
  int miscompares = 0, tests_run = 0, cyc = 0, n_res = 0, n_int = 0, t_exit, t_res;
  int t_pll;
  hmws_top #(.LOCK_CYCLES(LOCK), .OSC_DIV(DIV)) uut (.clk, .rstn, .idle_exec, .halt_mode_sel,
    .input_clock_halve_select, .crystal_used, .pll_bypass, .run_from_flash, .wake_int_en,
    .wake_gpio_pin, .external_reset_pin_n, .osc_stable, .system_clock_en, .clock_output_en,
    .core_clk_en, .periph_clk_en, .pll_power_down, .osc_power_down, .in_halt, .exec_resume,
    .wake_int_req);
  hmws_wake_src #(.OSC_DIV(DIV)) pm (.clk, .osc_power_down, .wake_gpio_pin,
    .external_reset_pin_n, .osc_stable);
  // Free-running 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict;
    if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  function automatic int exp_res(input logic from_flash);
    return from_flash ? 1125 : 35;
  endfunction : exp_res
  // Shortest lock wait in clk cycles: every oscillator tick is a divider period
  function automatic int exp_lock();
    return int'(LOCK) * int'(DIV);
  endfunction : exp_lock
  // Observed on the falling edge, where outputs have settled
  always @(negedge clk) begin
    cyc++;
    if (was_halt === 1'b1 && in_halt === 1'b0) t_exit = cyc;
    was_halt = in_halt;
    if (was_pd === 1'b1 && pll_power_down === 1'b0) t_pll = cyc;
    was_pd = pll_power_down;
    if (exec_resume === 1'b1) t_res = cyc;
    if (exec_resume === 1'b1) n_res++;
    if (wake_int_req === 1'b1) n_int++;
    if (cyc == 30000) begin
      miscompares++;
      give_verdict();
    end
  end
  // Random modes with r all low, then all high (pll_bypass low in both), first; refused entry right before each real one
  initial begin
    logic [4:0] r;
    int n0, i0, d, e;
    {rstn, idle_exec, halt_mode_sel, input_clock_halve_select} = 4'h0;
    {crystal_used, pll_bypass, run_from_flash, wake_int_en} = 4'h0;
    void'($urandom(32'h34bee02e));
    repeat (12) @(posedge clk);
    #1 rstn = 1'b1;
    check({clock_output_en, core_clk_en, in_halt, pll_power_down}, 4'hc);
    for (int i = 0; i < 8; i++) begin
      r = (i == 0) ? 5'h00 : (i == 1) ? 5'h1f : 5'($urandom);
      {wake_int_en, run_from_flash, crystal_used, input_clock_halve_select} = r[4:1];
      pll_bypass = r[0] ^ r[3];
      idle_exec = 1'b1;
      @(posedge clk);
      #1 halt_mode_sel = 1'b1;
      @(posedge clk);
      #1 idle_exec = 1'b0;
      repeat (31) @(posedge clk);
      #1 check({clock_output_en, in_halt}, 2'h2);
      repeat (2) @(posedge clk);
      #1 check({clock_output_en, in_halt}, {1'b0, ~input_clock_halve_select});
      repeat (32) @(posedge clk);
      #1 check({in_halt, system_clock_en, pll_power_down, osc_power_down}, {3'h5, crystal_used});
      idle_exec = 1'b1;
      @(posedge clk);
      #1 {idle_exec, halt_mode_sel} = 2'h0;
      n0 = n_res;
      i0 = n_int;
      pm.wake(r[0]);
      for (int t = 0; t < 1500 && n_res == n0; t++) @(posedge clk);
      repeat (40) @(posedge clk);
      // Delay keeps the next iteration's mode changes off the clock edge
      #1 check({system_clock_en, clock_output_en, core_clk_en, periph_clk_en, in_halt,
        pll_power_down, osc_power_down}, 7'h78);
      d = t_exit - t_pll;
      check(d >= exp_lock() && d <= exp_lock() + 16, 1'b1);
      d = t_res - t_exit;
      e = exp_res(run_from_flash);
      check(d >= e && d <= e + 3, 1'b1);
      check(n_res - n0, 1);
      check(n_int - i0, wake_int_en);
    end
    give_verdict();
  end
endmodule : tb_halt_mode_wake_sequencer
